// >>> rtl/jtag_dr_map.svh
`ifndef JTAG_DR_MAP_SVH
`define JTAG_DR_MAP_SVH

// ********************************************
// Instruction codes
// ********************************************
`define IR_W 6
`define IR_CHAIN_ONE 6'h02
`define IR_CHAIN_TWO 6'h03
`define IR_CHAIN_THREE 6'h22
`define IR_CHAIN_FOUR 6'h23
`define IR_CFG_OUT 6'h04
`define IR_CFG_IN 6'h05
`define IR_USER_CODE 6'h08
`define IR_DEVICE_ID 6'h09
`define IR_BYPASS 6'h3f

// ********************************************
// Data register layout and reset values
// ********************************************
`define DR_W 32
`define CHAIN_CNT 4
`define USER_CODE_RST 32'hffffffff
`define BYPASS_CAPTURE 1'b0
`define ID_FIXED_POS 0
`define ID_MAKER_LSB 0
`define ID_MAKER_W 12
`define ID_PART_LSB 12

`endif

// >>> rtl/jtag_dr_pkg.sv
package jtag_dr_pkg;

	// TAP controller states as the TAP presents them
	typedef enum logic [3:0] {
		ST_EX2_DR = 4'h0,
		ST_EX1_DR = 4'h1,
		ST_SH_DR = 4'h2,
		ST_PAU_DR = 4'h3,
		ST_SEL_IR = 4'h4,
		ST_UPD_DR = 4'h5,
		ST_CAP_DR = 4'h6,
		ST_SEL_DR = 4'h7,
		ST_EX2_IR = 4'h8,
		ST_EX1_IR = 4'h9,
		ST_SH_IR = 4'ha,
		ST_PAU_IR = 4'hb,
		ST_RTI = 4'hc,
		ST_UPD_IR = 4'hd,
		ST_CAP_IR = 4'he,
		ST_TLR = 4'hf
	} tap_state_e;

	// Which data register sits between TDI and TDO
	typedef enum logic [2:0] {
		SEL_BYPASS = 3'h0,
		SEL_DEVICE_ID = 3'h1,
		SEL_USER_CODE = 3'h2,
		SEL_CFG_BUS = 3'h3,
		SEL_FABRIC = 3'h4
	} dr_sel_e;

endpackage

// >>> rtl/dr_shift_reg.sv
`timescale 1ns/1ps
module dr_shift_reg #(
	parameter int W = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Control
	input wire logic capture_i,
	input wire logic shift_i,
	// Data
	input wire logic [W-1:0] cap_data_i,
	input wire logic sin_i,
	output logic [W-1:0] data_o
);

	logic [W-1:0] data_q;

	// Capture wins over shift, otherwise the register holds
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			data_q <= '0;
		end else if (capture_i) begin
			data_q <= cap_data_i;
		end else if (shift_i) begin
			data_q <= {sin_i, data_q[W-1:1]}; // R21
		end
	end

	assign data_o = data_q;

	// One step toward the serial output, LSB leaves first
	a_shift_step: assert property ( // R21
		@(posedge clk_i) disable iff (rst_i)
		(shift_i && !capture_i) |=> data_q == {$past(sin_i), $past(data_q[W-1:1])})
		else $error("shift register did not move one bit");

	// Stable between shifts
	a_hold_idle: assert property ( // R21
		@(posedge clk_i) disable iff (rst_i)
		(!shift_i && !capture_i) |=> $stable(data_q))
		else $error("shift register changed while idle");

endmodule

// >>> rtl/jtag_data_regs.sv
// Function
// R1: Bypass is one flop from TDI to TDO
// R2: Bypass flop loads zero in capture state
// R3: Fixed 32-bit device identity shifted on request
// R4: Identity bit 0 is one, low twelve maker
// R5: 32-bit register reaches configuration bus both ways
// R6: User code comes from image after configuration
// R7: Unconfigured or missing user code reads ones
// R8: Fabric chains exist only after configuration
// R9: One primitive instance per user chain
// R10: Fabric TDO registered on falling TCK edge
// R11: Chain select high while its instruction active
// R12: Data register clock driven to fabric
// R13: Reset, update, shift, capture decodes; TCK, TMS
// R14: TDI pin forwarded to fabric
// R15: Standard registers work without fabric chains
// R16: Boot pins strapped high-low-high for JTAG boot
// R17: Reload accepted after program or shutdown
// R18: Fabric chains only on the master die
// R19: Chain codes 02, 03, 22, 23 hex
// R20: User code 08, identity 09, bypass 3f
// R21: Hold between shifts, shift LSB first
`timescale 1ns/1ps
`include "jtag_dr_map.svh"
module jtag_data_regs #(
	parameter logic [19:0] PART_CODE = 20'h12345, // Arbitrary value
	parameter logic [11:0] MAKER_CODE = 12'h5a1, // Arbitrary value, bit 0 set
	parameter bit IS_MASTER_DIE = 1'b1
) (
	// System clock domain
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Configuration logic, system clock domain
	input wire logic config_done_i,
	input wire logic user_code_valid_i,
	input wire logic [`DR_W-1:0] user_code_i,
	input wire logic [`DR_W-1:0] cfg_rd_data_i,
	output logic [`DR_W-1:0] cfg_wr_data_o,
	output logic cfg_wr_valid_o,
	output logic cfg_rd_strobe_o,
	// TAP side, link clock domain
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	input wire jtag_dr_pkg::tap_state_e tap_next_i,
	input wire logic [`IR_W-1:0] ir_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	// Fabric scan chains
	input wire logic [`CHAIN_CNT-1:0] fabric_tdo_i,
	output logic [`CHAIN_CNT-1:0] chain_sel_o,
	output logic data_reg_clock_out_o,
	output logic fab_reset_o,
	output logic fab_update_o,
	output logic fab_shift_o,
	output logic fab_capture_o,
	output logic fab_tdi_o,
	output logic fab_tck_o,
	output logic fab_tms_o
);

	// ********************************************
	// Declarations
	// ********************************************
	localparam logic [`CHAIN_CNT*`IR_W-1:0] CHAIN_CODES =
		{`IR_CHAIN_FOUR, `IR_CHAIN_THREE, `IR_CHAIN_TWO, `IR_CHAIN_ONE};
	localparam logic [`DR_W-1:0] ID_WORD = {PART_CODE, MAKER_CODE};

	jtag_dr_pkg::tap_state_e st_q;
	jtag_dr_pkg::dr_sel_e dr_sel;
	logic tap_rst;
	logic [1:0] chain_idx;
	logic user_ok;
	logic bypass_q;
	logic [`DR_W-1:0] sr_data;
	logic [`DR_W-1:0] cap_word;
	logic sr_capture;
	logic sr_shift;
	logic tdo_q;
	logic tdo_oe_q;
	logic data_reg_clock_out_en_q;
	logic [`CHAIN_CNT-1:0] chain_sel_q;
	logic fab_reset_q;
	logic fab_update_q;
	logic fab_shift_q;
	logic fab_capture_q;
	// Configuration state, system side
	logic configured_q;
	logic [`DR_W-1:0] ucode_q;
	logic [`DR_W-1:0] rb_q;
	logic rb_ack_q;
	logic rq_s1_q, rq_s2_q, rq_s3_q;
	logic wq_s1_q, wq_s2_q, wq_s3_q;
	logic [`DR_W-1:0] cfg_wr_data_q;
	logic cfg_wr_valid_q;
	logic cfg_rd_strobe_q;
	// Crossing state, link side
	logic cfg_s1_q, cfg_s2_q;
	logic srst_s1_q, srst_s2_q;
	logic ack_s1_q, ack_s2_q;
	logic rb_req_q;
	logic wr_req_q;
	logic [`DR_W-1:0] wr_hold_q;
	logic rb_ready;
	logic cfg_out_upd;
	logic cfg_in_upd;

	// ********************************************
	// Instruction decode
	// ********************************************

	// Unknown codes fall back to bypass
	always_comb begin
		dr_sel = jtag_dr_pkg::SEL_BYPASS;
		chain_idx = 2'h0;
		unique case (ir_i)
			`IR_DEVICE_ID: dr_sel = jtag_dr_pkg::SEL_DEVICE_ID; // R20
			`IR_USER_CODE: dr_sel = jtag_dr_pkg::SEL_USER_CODE; // R20
			`IR_CFG_OUT, `IR_CFG_IN: dr_sel = jtag_dr_pkg::SEL_CFG_BUS;
			`IR_CHAIN_ONE: begin
				dr_sel = jtag_dr_pkg::SEL_FABRIC; // R19
				chain_idx = 2'h0;
			end
			`IR_CHAIN_TWO: begin
				dr_sel = jtag_dr_pkg::SEL_FABRIC; // R19
				chain_idx = 2'h1;
			end
			`IR_CHAIN_THREE: begin
				dr_sel = jtag_dr_pkg::SEL_FABRIC; // R19
				chain_idx = 2'h2;
			end
			`IR_CHAIN_FOUR: begin
				dr_sel = jtag_dr_pkg::SEL_FABRIC; // R19
				chain_idx = 2'h3;
			end
			default: dr_sel = jtag_dr_pkg::SEL_BYPASS; // R20
		endcase
	end

	// Chains answer only once configured and only on the master die
	assign user_ok = cfg_s2_q && IS_MASTER_DIE; // R8 R18
	assign tap_rst = (st_q == jtag_dr_pkg::ST_TLR);

	// ********************************************
	// TAP state tracking and fabric decodes
	// ********************************************

	// Registering the TAP's next state keeps these in step with the TAP
	always_ff @(posedge tck_i) begin
		st_q <= tap_next_i;
		fab_reset_q <= (tap_next_i == jtag_dr_pkg::ST_TLR); // R13
		fab_update_q <= (tap_next_i == jtag_dr_pkg::ST_UPD_DR); // R13
		fab_shift_q <= (tap_next_i == jtag_dr_pkg::ST_SH_DR); // R13
		fab_capture_q <= (tap_next_i == jtag_dr_pkg::ST_CAP_DR); // R13
	end

	// One select flop per fabric chain
	genvar g;
	generate
		for (g = 0; g < `CHAIN_CNT; g++) begin : g_chain
			always_ff @(posedge tck_i) begin
				if (tap_rst) begin
					chain_sel_q[g] <= 1'b0;
				end else begin
					chain_sel_q[g] <= user_ok && (ir_i == CHAIN_CODES[g*`IR_W +: `IR_W]); // R11
				end
			end

			a_chain_select: assert property ( // R11
				@(posedge tck_i) disable iff (tap_rst)
				(user_ok && ir_i == CHAIN_CODES[g*`IR_W +: `IR_W]) |=> chain_sel_q[g])
				else $error("chain select missing for active instruction");
		end
	endgenerate

	// ********************************************
	// Bypass and 32-bit registers
	// ********************************************

	// Bypass stage runs regardless of the fabric chains
	always_ff @(posedge tck_i) begin
		if (tap_rst) begin
			bypass_q <= `BYPASS_CAPTURE;
		end else if (st_q == jtag_dr_pkg::ST_CAP_DR) begin
			bypass_q <= `BYPASS_CAPTURE; // R2
		end else if (st_q == jtag_dr_pkg::ST_SH_DR) begin
			bypass_q <= tdi_i; // R1 R15
		end
	end

	// Parallel word for the shared 32-bit register
	always_comb begin
		cap_word = '0;
		unique case (dr_sel)
			jtag_dr_pkg::SEL_DEVICE_ID: cap_word = ID_WORD; // R3 R4
			jtag_dr_pkg::SEL_USER_CODE: cap_word = cfg_s2_q ? ucode_q : `USER_CODE_RST; // R6 R7
			jtag_dr_pkg::SEL_CFG_BUS: cap_word = (ir_i == `IR_CFG_OUT && rb_ready) ? rb_q : '0;
			default: cap_word = '0;
		endcase
	end

	assign sr_capture = (st_q == jtag_dr_pkg::ST_CAP_DR);
	assign sr_shift = (st_q == jtag_dr_pkg::ST_SH_DR);

	// One shift stage serves identity, user code and configuration bus
	dr_shift_reg #(
		.W(`DR_W)
	) u_shift (
		.clk_i(tck_i),
		.rst_i(tap_rst),
		.capture_i(sr_capture),
		.shift_i(sr_shift),
		.cap_data_i(cap_word),
		.sin_i(tdi_i),
		.data_o(sr_data)
	);

	// ********************************************
	// TDO path, falling edge
	// ********************************************

	// Outputs change on the falling edge so the host samples a settled bit
	always_ff @(negedge tck_i) begin
		if (tap_rst) begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_oe_q <= (st_q == jtag_dr_pkg::ST_SH_DR);
			unique case (dr_sel)
				jtag_dr_pkg::SEL_BYPASS: tdo_q <= bypass_q; // R1
				jtag_dr_pkg::SEL_FABRIC: tdo_q <= user_ok ? fabric_tdo_i[chain_idx] : bypass_q; // R10
				default: tdo_q <= sr_data[0]; // R3 R5
			endcase
		end
	end

	// Data register clock only runs for a selected chain in capture or shift
	always_ff @(negedge tck_i) begin
		if (tap_rst) begin
			data_reg_clock_out_en_q <= 1'b0;
		end else begin
			data_reg_clock_out_en_q <= (|chain_sel_q) && (sr_capture || sr_shift); // R12
		end
	end

	// ********************************************
	// Configuration state, system clock
	// ********************************************

	// User code tracks the image; all ones until valid
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			configured_q <= 1'b0;
			ucode_q <= `USER_CODE_RST;
		end else if (ce_i) begin
			configured_q <= config_done_i;
			if (config_done_i && user_code_valid_i) begin
				ucode_q <= user_code_i; // R6
			end else begin
				ucode_q <= `USER_CODE_RST; // R7
			end
		end
	end

	// Request toggles from the link side, first stage feeds only the second
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rq_s1_q <= 1'b0;
			rq_s2_q <= 1'b0;
			rq_s3_q <= 1'b0;
			wq_s1_q <= 1'b0;
			wq_s2_q <= 1'b0;
			wq_s3_q <= 1'b0;
		end else if (ce_i) begin
			rq_s1_q <= rb_req_q;
			rq_s2_q <= rq_s1_q;
			rq_s3_q <= rq_s2_q;
			wq_s1_q <= wr_req_q;
			wq_s2_q <= wq_s1_q;
			wq_s3_q <= wq_s2_q;
		end
	end

	// Readback fetch: take a word, tell the source to advance, acknowledge
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			rb_q <= '0;
			rb_ack_q <= 1'b0;
			cfg_rd_strobe_q <= 1'b0;
		end else if (ce_i) begin
			cfg_rd_strobe_q <= rq_s2_q ^ rq_s3_q; // R5
			if (rq_s2_q ^ rq_s3_q) begin
				rb_q <= cfg_rd_data_i; // R5
			end
			rb_ack_q <= rq_s3_q;
		end
	end

	// Load word, held stable on the link side until the next update
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			cfg_wr_data_q <= '0;
			cfg_wr_valid_q <= 1'b0;
		end else if (ce_i) begin
			cfg_wr_valid_q <= wq_s2_q ^ wq_s3_q; // R5 R17
			if (wq_s2_q ^ wq_s3_q) begin
				cfg_wr_data_q <= wr_hold_q;
			end
		end
	end

	// ********************************************
	// Crossing state, link clock
	// ********************************************

	assign cfg_out_upd = (st_q == jtag_dr_pkg::ST_UPD_DR) && (ir_i == `IR_CFG_OUT);
	assign cfg_in_upd = (st_q == jtag_dr_pkg::ST_UPD_DR) && (ir_i == `IR_CFG_IN);
	assign rb_ready = (ack_s2_q == rb_req_q);

	// Level and acknowledge synchronisers into the link domain
	always_ff @(posedge tck_i) begin
		cfg_s1_q <= configured_q;
		cfg_s2_q <= cfg_s1_q;
		ack_s1_q <= rb_ack_q;
		ack_s2_q <= ack_s1_q;
		srst_s1_q <= sys_rst_i;
		srst_s2_q <= srst_s1_q;
	end

	// Loads only while unconfigured, i.e. after program or shutdown
	// Toggles clear with their mclk partners: a TAP reset alone would fake an edge
	always_ff @(posedge tck_i) begin
		if (srst_s2_q) begin
			rb_req_q <= 1'b0;
			wr_req_q <= 1'b0;
			wr_hold_q <= '0;
		end else begin
			if (cfg_out_upd) begin
				rb_req_q <= ~rb_req_q; // R5
			end
			if (cfg_in_upd && !cfg_s2_q) begin
				wr_hold_q <= sr_data; // R17
				wr_req_q <= ~wr_req_q;
			end
		end
	end

	// ********************************************
	// Outputs
	// ********************************************
	assign tdo_o = tdo_q;
	assign tdo_oe_o = tdo_oe_q;
	assign chain_sel_o = chain_sel_q;
	assign fab_reset_o = fab_reset_q;
	assign fab_update_o = fab_update_q;
	assign fab_shift_o = fab_shift_q;
	assign fab_capture_o = fab_capture_q;
	assign cfg_wr_data_o = cfg_wr_data_q;
	assign cfg_wr_valid_o = cfg_wr_valid_q;
	assign cfg_rd_strobe_o = cfg_rd_strobe_q;
	// Pin pass-through, no flop so the fabric sees the same edges
	assign fab_tdi_o = tdi_i; // R14
	assign fab_tck_o = tck_i; // R13
	assign fab_tms_o = tms_i; // R13
	// Gated clock, parked high when idle; enable changes while TCK is low
	assign data_reg_clock_out_o = data_reg_clock_out_en_q ? tck_i : 1'b1; // R12

	// ********************************************
	// Checks
	// ********************************************

	a_bypass_capture_zero: assert property ( // R2
		@(posedge tck_i) disable iff (tap_rst)
		(st_q == jtag_dr_pkg::ST_CAP_DR) |=> !bypass_q)
		else $error("bypass not cleared in capture");

	a_bypass_one_stage: assert property ( // R1
		@(posedge tck_i) disable iff (tap_rst)
		(st_q == jtag_dr_pkg::ST_SH_DR && dr_sel == jtag_dr_pkg::SEL_BYPASS)
		|=> bypass_q == $past(tdi_i))
		else $error("bypass stage lost TDI bit");

	a_bypass_tdo_out: assert property ( // R15
		@(negedge tck_i) disable iff (tap_rst)
		(dr_sel == jtag_dr_pkg::SEL_BYPASS && st_q == jtag_dr_pkg::ST_SH_DR)
		|=> tdo_q == $past(bypass_q))
		else $error("TDO does not follow bypass stage");

	a_identity_capture: assert property ( // R3
		@(posedge tck_i) disable iff (tap_rst)
		(sr_capture && dr_sel == jtag_dr_pkg::SEL_DEVICE_ID) |=> sr_data == ID_WORD)
		else $error("identity word not captured");

	a_identity_maker: assert property ( // R4
		@(posedge tck_i) disable iff (tap_rst)
		(sr_capture && dr_sel == jtag_dr_pkg::SEL_DEVICE_ID)
		|=> sr_data[`ID_FIXED_POS] && sr_data[`ID_MAKER_W-1:`ID_MAKER_LSB] == MAKER_CODE)
		else $error("identity maker field wrong");

	a_ucode_unconfig: assert property ( // R7
		@(posedge tck_i) disable iff (tap_rst)
		(sr_capture && dr_sel == jtag_dr_pkg::SEL_USER_CODE && !cfg_s2_q)
		|=> sr_data == `USER_CODE_RST)
		else $error("unconfigured user code not all ones");

	a_ucode_source: assert property ( // R6
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && config_done_i && user_code_valid_i) |=> ucode_q == $past(user_code_i))
		else $error("user code not taken from image");

	a_fabric_tdo_fall: assert property ( // R10
		@(negedge tck_i) disable iff (tap_rst)
		(dr_sel == jtag_dr_pkg::SEL_FABRIC && user_ok)
		|=> tdo_q == $past(fabric_tdo_i[chain_idx]))
		else $error("fabric TDO not registered on falling edge");

	a_chain_needs_cfg: assert property ( // R8 R18
		@(posedge tck_i) disable iff (tap_rst)
		(|chain_sel_q) |-> $past(cfg_s2_q) && IS_MASTER_DIE)
		else $error("chain selected while unconfigured");

	a_decode_shift: assert property ( // R13
		@(posedge tck_i)
		(tap_next_i == jtag_dr_pkg::ST_SH_DR) |=> fab_shift_q && !fab_capture_q && !fab_update_q)
		else $error("shift decode wrong");

	a_load_one_pulse: assert property ( // R5
		@(posedge mclk_i) disable iff (sys_rst_i)
		(ce_i && cfg_wr_valid_q) |=> !cfg_wr_valid_q)
		else $error("load strobe longer than one cycle");

	a_load_when_unconf: assert property ( // R17
		@(posedge tck_i) disable iff (tap_rst || srst_s2_q)
		(cfg_in_upd && !cfg_s2_q) |=> wr_req_q != $past(wr_req_q) && wr_hold_q == $past(sr_data))
		else $error("load word not handed over");

endmodule

// >>> verif/fabric_chain_model.sv
`timescale 1ns/1ps
// ****************************************
// Fabric scan chain stand-in
// ****************************************
module fabric_chain_model #(
	parameter int CHAIN = 0
) (
	// Scan controls from the device
	input wire logic data_reg_clock_out_i,
	input wire logic sel_i,
	input wire logic capture_i,
	input wire logic shift_i,
	input wire logic tdi_i,
	// Serial answer
	output logic tdo_o
);
	logic [31:0] sr_q;
	// Own pattern per chain, shifted LSB first
	always_ff @(posedge data_reg_clock_out_i) begin
		if (sel_i && capture_i) begin
			sr_q <= 32'h5ca1_0000 + 32'(CHAIN);
		end else if (sel_i && shift_i) begin
			sr_q <= {tdi_i, sr_q[31:1]};
		end
	end
	// Unselected chain shows the inverse of its held bit 0
	assign tdo_o = sel_i ? sr_q[0] : ~sr_q[0];
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
`include "jtag_dr_map.svh"
module tb;
	// ****************************************
	// Constants and signals
	// ****************************************
	localparam logic [19:0] PART = 20'h6c2e1; // Arbitrary value
	localparam logic [11:0] MAKER = 12'h3a7; // Arbitrary value, bit 0 set
	localparam logic [31:0] DIN = 32'h3cc3_a55a;
	localparam logic [31:0] UCODE = 32'h1234_abcd;
	localparam logic [31:0] RB_WORD = 32'h0e1f_7788;
	localparam logic [31:0] LOAD = 32'h9d2b_41e6;
	typedef struct {
		logic [5:0] ir;
		bit cfg;
		bit byp;
		logic [31:0] exp;
		logic [3:0] sel;
	} row_s;
	logic mclk_i = 0;
	logic sys_rst_i = 1;
	logic ce_i = 1;
	logic config_done_i = 0;
	logic user_code_valid_i = 1;
	logic [31:0] user_code_i = UCODE;
	logic [31:0] cfg_rd_data_i = RB_WORD;
	logic [31:0] cfg_wr_data_o;
	logic cfg_wr_valid_o, cfg_rd_strobe_o, tdo_o, tdo_oe_o, data_reg_clock_out;
	logic tck_i = 0;
	logic tck_en = 1;
	logic tms_i = 1;
	logic tdi_i = 0;
	jtag_dr_pkg::tap_state_e tap_next_i = jtag_dr_pkg::ST_TLR;
	logic [5:0] ir_i = `IR_BYPASS;
	logic fab_reset_o, fab_update_o, fab_shift_o, fab_capture_o, fab_tdi_o, fab_tck_o, fab_tms_o;
	logic [3:0] fabric_tdo_i, chain_sel_o;
	int errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int wr_cnt = 0;
	int rd_cnt = 0;
	logic [31:0] wr_word, got;
	row_s rows[10];

	// System clock
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end
	// Link clock, offset phase, stops low between scans
	initial begin
		#3;
		forever begin
			#6;
			if (tck_en || tck_i) begin
				tck_i = ~tck_i;
			end
		end
	end

	jtag_data_regs #(.PART_CODE(PART), .MAKER_CODE(MAKER), .IS_MASTER_DIE(1'b1)) DUT (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .config_done_i(config_done_i),
		.user_code_valid_i(user_code_valid_i), .user_code_i(user_code_i),
		.cfg_rd_data_i(cfg_rd_data_i), .cfg_wr_data_o(cfg_wr_data_o),
		.cfg_wr_valid_o(cfg_wr_valid_o), .cfg_rd_strobe_o(cfg_rd_strobe_o), .tck_i(tck_i),
		.tms_i(tms_i), .tdi_i(tdi_i), .tap_next_i(tap_next_i), .ir_i(ir_i), .tdo_o(tdo_o),
		.tdo_oe_o(tdo_oe_o), .fabric_tdo_i(fabric_tdo_i), .chain_sel_o(chain_sel_o),
		.data_reg_clock_out_o(data_reg_clock_out), .fab_reset_o(fab_reset_o), .fab_update_o(fab_update_o),
		.fab_shift_o(fab_shift_o), .fab_capture_o(fab_capture_o), .fab_tdi_o(fab_tdi_o),
		.fab_tck_o(fab_tck_o), .fab_tms_o(fab_tms_o));

	// One fabric model per chain, each with its own index
	for (genvar g = 0; g < 4; g++) begin : g_chain
		fabric_chain_model #(.CHAIN(g)) fab (.data_reg_clock_out_i(data_reg_clock_out), .sel_i(chain_sel_o[g]),
			.capture_i(fab_capture_o), .shift_i(fab_shift_o), .tdi_i(fab_tdi_o),
			.tdo_o(fabric_tdo_i[g]));
	end

	// Load pulse watcher and hang guard
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cfg_wr_valid_o === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			wr_word <= cfg_wr_data_o;
		end
		if (cfg_rd_strobe_o === 1'b1) begin
			rd_cnt <= rd_cnt + 1;
		end
		if (cycles == 20000) begin
			errors = errors + 1;
			test_done();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Full DR scan: idle, capture, n shifts, update, idle
	task automatic scan(input logic [5:0] code, input logic [31:0] din, input int n,
		output logic [31:0] dout);
		dout = '0;
		tck_en = 1;
		@(posedge tck_i);
		ir_i <= code;
		tms_i <= 1'b0;
		tap_next_i <= jtag_dr_pkg::ST_RTI;
		repeat (6) @(posedge tck_i);
		tap_next_i <= jtag_dr_pkg::ST_SEL_DR;
		@(posedge tck_i);
		tap_next_i <= jtag_dr_pkg::ST_CAP_DR;
		@(posedge tck_i);
		tap_next_i <= jtag_dr_pkg::ST_SH_DR;
		@(posedge tck_i);
		for (int j = 0; j < n; j++) begin
			tdi_i <= din[j];
			if (j == n - 1) begin
				tap_next_i <= jtag_dr_pkg::ST_EX1_DR;
			end
			@(posedge tck_i);
			dout[j] = tdo_o;
			chk("tdo_oe_o", 32'(tdo_oe_o), 32'h1);
			chk("fab_tdi_o", 32'(fab_tdi_o), 32'(tdi_i));
			chk("fab_tms_o", 32'(fab_tms_o), 32'(tms_i));
		end
		// Released line shows the inverse, not the last bit
		tdi_i <= ~din[n-1];
		tap_next_i <= jtag_dr_pkg::ST_UPD_DR;
		@(posedge tck_i);
		tap_next_i <= jtag_dr_pkg::ST_RTI;
		tms_i <= 1'b1;
		repeat (4) @(posedge tck_i);
		tck_en = 0;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rows[0] = '{`IR_DEVICE_ID, 0, 0, {PART, MAKER}, 4'h0};
		rows[1] = '{`IR_USER_CODE, 0, 0, `USER_CODE_RST, 4'h0};
		rows[2] = '{`IR_BYPASS, 0, 1, 32'h0, 4'h0};
		rows[3] = '{6'h15, 0, 1, 32'h0, 4'h0};
		rows[4] = '{`IR_CHAIN_ONE, 0, 1, 32'h0, 4'h0};
		rows[5] = '{`IR_USER_CODE, 1, 0, UCODE, 4'h0};
		rows[6] = '{`IR_CHAIN_ONE, 1, 0, 32'h5ca1_0000, 4'h1};
		rows[7] = '{`IR_CHAIN_TWO, 1, 0, 32'h5ca1_0001, 4'h2};
		rows[8] = '{`IR_CHAIN_THREE, 1, 0, 32'h5ca1_0002, 4'h4};
		rows[9] = '{`IR_CHAIN_FOUR, 1, 0, 32'h5ca1_0003, 4'h8};
		// Reset both domains together
		repeat (20) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		@(posedge mclk_i);
		chk("tdo_oe_o", 32'(tdo_oe_o), 32'h0);
		chk("chain_sel_o", 32'(chain_sel_o), 32'h0);
		chk("fab_reset_o", 32'(fab_reset_o), 32'h1);
		chk("cfg_wr_valid_o", 32'(cfg_wr_valid_o), 32'h0);
		$display("test reset done");
		// Readback is fetched ahead: first word is zero
		scan(`IR_CFG_OUT, DIN, 32, got);
		chk("readback first", got, 32'h0);
		repeat (10) @(posedge mclk_i);
		scan(`IR_CFG_OUT, DIN, 32, got);
		chk("readback word", got, RB_WORD);
		$display("test readback done");
		// Load while unconfigured reaches the bus once
		scan(`IR_CFG_IN, LOAD, 32, got);
		repeat (10) @(posedge mclk_i);
		chk("load count", 32'(wr_cnt), 32'h1);
		chk("strobe count", 32'(rd_cnt), 32'h2);
		chk("load word", wr_word, LOAD);
		$display("test load done");
		// Register table
		for (int i = 0; i < 10; i++) begin
			if (rows[i].cfg && !config_done_i) begin
				@(posedge mclk_i);
				config_done_i <= 1'b1;
				repeat (5) @(posedge mclk_i);
			end
			scan(rows[i].ir, DIN, 32, got);
			chk("scan word", got, rows[i].byp ? {DIN[30:0], 1'b0} : rows[i].exp);
			chk("chain_sel_o", 32'(chain_sel_o), 32'(rows[i].sel));
			chk("tdo_oe_o idle", 32'(tdo_oe_o), 32'h0);
			// Look with TCK low, where a stuck gate would show
			@(negedge tck_i);
			#1;
			chk("data_reg_clock_out idle", 32'(data_reg_clock_out), 32'h1);
			$display("test row %0d done", i);
		end
		// TAP reset mid-run drops the select and must not fake a load
		tck_en = 1;
		@(posedge tck_i);
		tap_next_i <= jtag_dr_pkg::ST_TLR;
		repeat (3) @(posedge tck_i);
		chk("chain_sel_o reset", 32'(chain_sel_o), 32'h0);
		chk("fab_reset_o mid-run", 32'(fab_reset_o), 32'h1);
		tap_next_i <= jtag_dr_pkg::ST_RTI;
		@(posedge tck_i);
		tck_en = 0;
		$display("test tap reset done");
		// Frozen clock enable keeps the old user code, then the image loses it
		ce_i <= 1'b0;
		user_code_valid_i <= 1'b0;
		scan(`IR_USER_CODE, DIN, 32, got);
		chk("user code frozen", got, UCODE);
		ce_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		scan(`IR_USER_CODE, DIN, 32, got);
		chk("user code absent", got, `USER_CODE_RST);
		$display("test user code done");
		// Load after configuration is ignored
		scan(`IR_CFG_IN, ~LOAD, 32, got);
		repeat (10) @(posedge mclk_i);
		chk("load ignored", 32'(wr_cnt), 32'h1);
		// Identity still readable with chains unused
		scan(`IR_DEVICE_ID, DIN, 32, got);
		chk("identity again", got, {PART, MAKER});
		$display("test configured done");
		test_done();
	end
endmodule
